// ==== logic/cbo_config_regs.sv ====
`timescale 1ns/1ns
module cbo_config_regs #(
  parameter logic [1:0] VARIANT = cbo_pkg::VARIANT_100,
  parameter logic [7:0] FACTORY_IMP = 8'haa
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic wr_en_in,
  input wire logic [cbo_pkg::ADDR_W-1:0] addr_in,
  input wire logic [cbo_pkg::DATA_W-1:0] wr_data_in,
  output logic [cbo_pkg::DATA_W-1:0] rd_data_out,
  input wire logic [3:0] gate_pin_in,
  input wire logic power_good_powerdown_pin_in,
  output logic [3:0] pair_enable_out,
  output logic [1:0] pair_true_drive_out,
  output logic [1:0] pair_comp_drive_out,
  output logic stop_hiz_out,
  output logic [1:0] stop_state_sel_out,
  output logic [7:0] pair_impedance_sel_out,
  output logic [1:0] feedback_impedance_sel_out,
  output logic [7:0] output_gate_pull_sel_out,
  output logic [1:0] bandwidth_bypass_pull_sel_out,
  output logic [1:0] power_good_pull_sel_out,
  output logic [3:0] output_gate_polarity_out,
  output logic powerdown_polarity_out,
  output logic powerdown_out
);
  // Factory code is loaded for every output on the programmable variant
  function automatic logic [1:0] imp_default(input logic [1:0] factory);
    case (VARIANT)
      cbo_pkg::VARIANT_85: imp_default = cbo_pkg::IMP_85;
      cbo_pkg::VARIANT_PROG: imp_default = factory;
      default: imp_default = cbo_pkg::IMP_100;
    endcase
  endfunction : imp_default

  logic [1:0] stop_ff;
  logic [1:0] feedback_impedance_sel_ff;
  logic [7:0] imp_ff;
  logic [7:0] gpull_ff;
  logic [1:0] bw_pull_ff;
  logic [1:0] pg_pull_ff;
  logic [3:0] gpol_ff;
  logic pd_pol_ff;
  logic keep_ff;
  logic pd_now;
  logic clear_cfg;

  // Power-down when the pin level equals the polarity bit
  assign pd_now = power_good_powerdown_pin_in ~^ pd_pol_ff;
  assign clear_cfg = pd_now && !keep_ff;

  // Defaults are reapplied while in power-down when restore says clear
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stop_ff <= cbo_pkg::STOP_RST;
      feedback_impedance_sel_ff <= imp_default(FACTORY_IMP[1:0]);
      imp_ff <= {imp_default(FACTORY_IMP[7:6]), imp_default(FACTORY_IMP[5:4]),
        imp_default(FACTORY_IMP[3:2]), imp_default(FACTORY_IMP[1:0])};
      gpull_ff <= {4{cbo_pkg::PULL_DOWN}};
      bw_pull_ff <= cbo_pkg::PULL_BOTH;
      pg_pull_ff <= cbo_pkg::PULL_UP;
      gpol_ff <= 4'h0;
      pd_pol_ff <= 1'b0;
    end
    else if (clear_cfg)
    begin
      stop_ff <= cbo_pkg::STOP_RST;
      feedback_impedance_sel_ff <= imp_default(FACTORY_IMP[1:0]);
      imp_ff <= {imp_default(FACTORY_IMP[7:6]), imp_default(FACTORY_IMP[5:4]),
        imp_default(FACTORY_IMP[3:2]), imp_default(FACTORY_IMP[1:0])};
      gpull_ff <= {4{cbo_pkg::PULL_DOWN}};
      bw_pull_ff <= cbo_pkg::PULL_BOTH;
      pg_pull_ff <= cbo_pkg::PULL_UP;
      gpol_ff <= 4'h0;
      // Polarity of the power-down pin itself is kept, or clearing it could end power-down at once
    end
    // Writes are refused while a clearing power-down holds the defaults,
    // so the host must leave power-down or first set the restore bit to keep before it reprograms any byte but the restore byte
    else if (wr_en_in)
    begin
      case (addr_in)
        cbo_pkg::OFS_STOP_FB:
        begin
          stop_ff <= wr_data_in[cbo_pkg::STOP_LSB +: 2];
          feedback_impedance_sel_ff <= wr_data_in[cbo_pkg::FEEDBACK_IMPEDANCE_SEL_LSB +: 2];
        end
        // Reserved code 11 is stored as written; keeping it out is the host's duty
        cbo_pkg::OFS_IMP_LO:
        begin
          imp_ff[1:0] <= wr_data_in[cbo_pkg::IMP_LO_A_LSB +: 2];
          imp_ff[3:2] <= wr_data_in[cbo_pkg::IMP_LO_B_LSB +: 2];
        end
        cbo_pkg::OFS_IMP_HI:
        begin
          imp_ff[5:4] <= wr_data_in[cbo_pkg::IMP_HI_A_LSB +: 2];
          imp_ff[7:6] <= wr_data_in[cbo_pkg::IMP_HI_B_LSB +: 2];
        end
        // Gate pull bytes reuse the impedance byte layout
        cbo_pkg::OFS_PULL_LO:
        begin
          gpull_ff[1:0] <= wr_data_in[cbo_pkg::IMP_LO_A_LSB +: 2];
          gpull_ff[3:2] <= wr_data_in[cbo_pkg::IMP_LO_B_LSB +: 2];
        end
        cbo_pkg::OFS_PULL_HI:
        begin
          gpull_ff[5:4] <= wr_data_in[cbo_pkg::IMP_HI_A_LSB +: 2];
          gpull_ff[7:6] <= wr_data_in[cbo_pkg::IMP_HI_B_LSB +: 2];
        end
        cbo_pkg::OFS_MODE_PULL:
        begin
          bw_pull_ff <= wr_data_in[cbo_pkg::BW_PULL_LSB +: 2];
          pg_pull_ff <= wr_data_in[cbo_pkg::PG_PULL_LSB +: 2];
        end
        cbo_pkg::OFS_GATE_POL:
        begin
          gpol_ff <= {wr_data_in[cbo_pkg::POL_D_BIT], wr_data_in[cbo_pkg::POL_C_BIT],
            wr_data_in[cbo_pkg::POL_B_BIT], wr_data_in[cbo_pkg::POL_A_BIT]};
        end
        cbo_pkg::OFS_PD_POL: pd_pol_ff <= wr_data_in[cbo_pkg::PD_POL_BIT];
        default: ;
      endcase
    end
  end

  // Restore choice survives power-down so it can steer the next one
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      keep_ff <= 1'b0;
    else if (wr_en_in && addr_in == cbo_pkg::OFS_PD_RESTORE)
      keep_ff <= wr_data_in[cbo_pkg::PD_RESTORE_BIT];
  end

  // Read-back: reserved bits return zero
  always_comb
  begin
    rd_data_out = 8'h00;
    case (addr_in)
      cbo_pkg::OFS_PD_RESTORE: rd_data_out[cbo_pkg::PD_RESTORE_BIT] = keep_ff;
      cbo_pkg::OFS_STOP_FB:
      begin
        rd_data_out[cbo_pkg::STOP_LSB +: 2] = stop_ff;
        rd_data_out[cbo_pkg::FEEDBACK_IMPEDANCE_SEL_LSB +: 2] = feedback_impedance_sel_ff;
      end
      cbo_pkg::OFS_IMP_LO:
      begin
        rd_data_out[cbo_pkg::IMP_LO_A_LSB +: 2] = imp_ff[1:0];
        rd_data_out[cbo_pkg::IMP_LO_B_LSB +: 2] = imp_ff[3:2];
      end
      cbo_pkg::OFS_IMP_HI:
      begin
        rd_data_out[cbo_pkg::IMP_HI_A_LSB +: 2] = imp_ff[5:4];
        rd_data_out[cbo_pkg::IMP_HI_B_LSB +: 2] = imp_ff[7:6];
      end
      cbo_pkg::OFS_PULL_LO:
      begin
        rd_data_out[cbo_pkg::IMP_LO_A_LSB +: 2] = gpull_ff[1:0];
        rd_data_out[cbo_pkg::IMP_LO_B_LSB +: 2] = gpull_ff[3:2];
      end
      cbo_pkg::OFS_PULL_HI:
      begin
        rd_data_out[cbo_pkg::IMP_HI_A_LSB +: 2] = gpull_ff[5:4];
        rd_data_out[cbo_pkg::IMP_HI_B_LSB +: 2] = gpull_ff[7:6];
      end
      cbo_pkg::OFS_MODE_PULL:
      begin
        rd_data_out[cbo_pkg::BW_PULL_LSB +: 2] = bw_pull_ff;
        rd_data_out[cbo_pkg::PG_PULL_LSB +: 2] = pg_pull_ff;
      end
      cbo_pkg::OFS_GATE_POL:
      begin
        rd_data_out[cbo_pkg::POL_A_BIT] = gpol_ff[0];
        rd_data_out[cbo_pkg::POL_B_BIT] = gpol_ff[1];
        rd_data_out[cbo_pkg::POL_C_BIT] = gpol_ff[2];
        rd_data_out[cbo_pkg::POL_D_BIT] = gpol_ff[3];
      end
      cbo_pkg::OFS_PD_POL: rd_data_out[cbo_pkg::PD_POL_BIT] = pd_pol_ff;
      default: rd_data_out = 8'h00;
    endcase
  end

  // A pair runs only when its gate pin matches polarity and power is up
  assign pair_enable_out = (gate_pin_in ~^ gpol_ff) & {4{!pd_now}};

  // Disabled-state drive decode, shared by all pairs
  always_comb
  begin
    stop_hiz_out = 1'b0;
    pair_true_drive_out = 2'h0;
    case (stop_ff)
      cbo_pkg::STOP_HIZ: stop_hiz_out = 1'b1;
      cbo_pkg::STOP_HIGH_LOW: pair_true_drive_out = 2'h1;
      cbo_pkg::STOP_LOW_HIGH: pair_true_drive_out = 2'h2;
      default: pair_true_drive_out = 2'h0;
    endcase
  end
  // Complement leg only flags hi-z; low/high is read from the state field
  assign pair_comp_drive_out = {stop_hiz_out, 1'b0};

  assign stop_state_sel_out = stop_ff;
  assign pair_impedance_sel_out = imp_ff;
  assign feedback_impedance_sel_out = feedback_impedance_sel_ff;
  assign output_gate_pull_sel_out = gpull_ff;
  assign bandwidth_bypass_pull_sel_out = bw_pull_ff;
  assign power_good_pull_sel_out = pg_pull_ff;
  assign output_gate_polarity_out = gpol_ff;
  assign powerdown_polarity_out = pd_pol_ff;
  assign powerdown_out = pd_now;
endmodule : cbo_config_regs

// ==== logic/cbo_pkg.sv ====
package cbo_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_STOP_FB = 8'h0b;
  localparam logic [7:0] OFS_IMP_LO = 8'h0c;
  localparam logic [7:0] OFS_IMP_HI = 8'h0d;
  localparam logic [7:0] OFS_PULL_LO = 8'h0e;
  localparam logic [7:0] OFS_PULL_HI = 8'h0f;
  localparam logic [7:0] OFS_MODE_PULL = 8'h10;
  localparam logic [7:0] OFS_GATE_POL = 8'h12;
  localparam logic [7:0] OFS_PD_POL = 8'h13;
  // Restore-control byte, kept here so power-down behaviour is software steerable
  localparam logic [7:0] OFS_PD_RESTORE = 8'h0a;
  localparam int PD_RESTORE_BIT = 6;
  // Field positions
  localparam int STOP_LSB = 0;
  localparam int FEEDBACK_IMPEDANCE_SEL_LSB = 6;
  localparam int IMP_LO_A_LSB = 2;
  localparam int IMP_LO_B_LSB = 6;
  localparam int IMP_HI_A_LSB = 0;
  localparam int IMP_HI_B_LSB = 4;
  localparam int BW_PULL_LSB = 2;
  localparam int PG_PULL_LSB = 0;
  localparam int POL_A_BIT = 1;
  localparam int POL_B_BIT = 3;
  localparam int POL_C_BIT = 4;
  localparam int POL_D_BIT = 6;
  localparam int PD_POL_BIT = 0;
  // Codes
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [1:0] STOP_LOW_LOW = 2'h0;
  localparam logic [1:0] STOP_HIZ = 2'h1;
  localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
  localparam logic [1:0] STOP_LOW_HIGH = 2'h3;
  localparam logic [1:0] IMP_100 = 2'h2;
  localparam logic [1:0] IMP_85 = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_BOTH = 2'h3;
  localparam logic [1:0] VARIANT_100 = 2'h0;
  localparam logic [1:0] VARIANT_85 = 2'h1;
  localparam logic [1:0] VARIANT_PROG = 2'h2;
endpackage : cbo_pkg

// ==== testbench/cbo_config_regs_asserts.sv ====
`timescale 1ns/1ns
module cbo_config_regs_asserts (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [3:0] gate_pin_in,
  input wire logic power_good_powerdown_pin_in,
  input wire logic [3:0] pair_enable_out,
  input wire logic stop_hiz_out,
  input wire logic [1:0] stop_state_sel_out,
  input wire logic [7:0] pair_impedance_sel_out,
  input wire logic [1:0] feedback_impedance_sel_out,
  input wire logic [7:0] output_gate_pull_sel_out,
  input wire logic [3:0] output_gate_polarity_out,
  input wire logic powerdown_polarity_out,
  input wire logic powerdown_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  wire wr_ok = wr_en_in && !powerdown_out;
  property p_stop; wr_ok && addr_in == 8'h0b ##1 !powerdown_out |->
    {feedback_impedance_sel_out, stop_state_sel_out} == $past({wr_data_in[7:6], wr_data_in[1:0]});
  endproperty
  a_stop: assert property (p_stop) else $error("stop byte");
  property p_imp; wr_ok && addr_in == 8'h0c ##1 !powerdown_out |->
    pair_impedance_sel_out[3:0] == $past({wr_data_in[7:6], wr_data_in[3:2]}); endproperty
  a_imp: assert property (p_imp) else $error("impedance");
  property p_pol; wr_ok && addr_in == 8'h12 ##1 !powerdown_out |->
    output_gate_polarity_out == $past({wr_data_in[6], wr_data_in[4:3], wr_data_in[1]}); endproperty
  a_pol: assert property (p_pol) else $error("gate polarity");
  property p_pdpol; wr_ok && addr_in == 8'h13 |=>
    powerdown_polarity_out == $past(wr_data_in[0]); endproperty
  a_pdpol: assert property (p_pdpol) else $error("pd polarity");
  property p_pd; powerdown_out == (power_good_powerdown_pin_in == powerdown_polarity_out);
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown");
  property p_en; pair_enable_out ==
    (~(gate_pin_in ^ output_gate_polarity_out) & {4{!powerdown_out}}); endproperty
  a_en: assert property (p_en) else $error("pair enable");
  property p_hiz; stop_hiz_out == (stop_state_sel_out == 2'h1); endproperty
  a_hiz: assert property (p_hiz) else $error("hiz");
  property p_rst; $rose(rst_b_in) |-> stop_state_sel_out == 2'h0 && pair_impedance_sel_out == 8'haa
    && output_gate_pull_sel_out == 8'h55 && output_gate_polarity_out == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("defaults");
endmodule : cbo_config_regs_asserts
bind cbo_config_regs cbo_config_regs_asserts i_cbo_config_regs_asserts (.clock_in, .rst_b_in,
  .wr_en_in, .addr_in, .wr_data_in, .gate_pin_in, .power_good_powerdown_pin_in, .pair_enable_out,
  .stop_hiz_out, .stop_state_sel_out, .pair_impedance_sel_out, .feedback_impedance_sel_out,
  .output_gate_pull_sel_out, .output_gate_polarity_out, .powerdown_polarity_out, .powerdown_out);

// ==== testbench/cbo_config_regs_tb_top.sv ====
`timescale 1ns/1ns
module cbo_config_regs_tb_top;
  logic clock_in, rst_b_in, wr_en_in, power_good_powerdown_pin_in, stop_hiz_out, powerdown_out;
  logic [7:0] addr_in, wr_data_in, rd_data_out, pair_impedance_sel_out, output_gate_pull_sel_out, r;
  logic [3:0] gate_pin_in, pair_enable_out, output_gate_polarity_out;
  logic [1:0] stop_state_sel_out, feedback_impedance_sel_out;
  logic [1:0] pair_true_drive_out, pair_comp_drive_out;
  logic [1:0] bandwidth_bypass_pull_sel_out, power_good_pull_sel_out;
  logic [7:0] drv [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
  logic powerdown_polarity_out;
  int n_errors, samples_checked, cyc;
  logic [7:0] dflt [10] = '{8'h00, 8'h80, 8'h88, 8'h22, 8'h44, 8'h11, 8'h0e, 8'h00, 8'h00, 8'h00};
  cbo_config_regs i_cbo_config_regs (.clock_in, .rst_b_in, .wr_en_in, .addr_in, .wr_data_in,
    .rd_data_out, .gate_pin_in, .power_good_powerdown_pin_in, .pair_enable_out,
    .pair_true_drive_out, .pair_comp_drive_out, .stop_hiz_out, .stop_state_sel_out,
    .pair_impedance_sel_out, .feedback_impedance_sel_out, .output_gate_pull_sel_out,
    .bandwidth_bypass_pull_sel_out, .power_good_pull_sel_out, .output_gate_polarity_out,
    .powerdown_polarity_out, .powerdown_out);
  cbo_host_model i_cbo_host_model (.clock_in, .rd_data_in(rd_data_out), .wr_en_out(wr_en_in),
    .addr_out(addr_in), .wr_data_out(wr_data_in));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic check_defaults;
    logic [7:0] v;
    for (int i = 0; i < 10; i++)
    begin
      i_cbo_host_model.rd(8'h0a + 8'(i), v);
      chk("dflt", v, dflt[i]);
    end
    chk("mpull", 8'({bandwidth_bypass_pull_sel_out, power_good_pull_sel_out}), 8'h0e);
  endtask : check_defaults
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic step;
    @(posedge clock_in);
    #1;
  endtask : step
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    rst_b_in = 1'b0;
    gate_pin_in = 4'h0;
    power_good_powerdown_pin_in = 1'b1;
    repeat (8) @(posedge clock_in);
    #1;
    rst_b_in = 1'b1;
    check_defaults();
    chk("en", 8'(pair_enable_out), 8'h0f);
    for (int c = 0; c < 4; c++)
    begin
      i_cbo_host_model.wr(8'h0b, {6'h10, 2'(c)});
      chk("stop", 8'(stop_state_sel_out), 8'(c));
      chk("hiz", 8'(stop_hiz_out), 8'(c == 1));
      chk("drv", 8'({pair_true_drive_out, pair_comp_drive_out}), drv[c]);
    end
    chk("fb", 8'(feedback_impedance_sel_out), 8'h01);
    i_cbo_host_model.wr(8'h0c, 8'h04);
    i_cbo_host_model.wr(8'h0d, 8'h20);
    chk("imp", pair_impedance_sel_out, 8'h81);
    i_cbo_host_model.wr(8'h0e, 8'h08);
    i_cbo_host_model.wr(8'h0f, 8'h13);
    chk("pull", output_gate_pull_sel_out, 8'h72);
    i_cbo_host_model.wr(8'h10, 8'h09);
    chk("mpull", 8'({bandwidth_bypass_pull_sel_out, power_good_pull_sel_out}), 8'h09);
    i_cbo_host_model.wr(8'h11, 8'hff);
    i_cbo_host_model.rd(8'h11, r);
    chk("unmap", r, 8'h00);
    i_cbo_host_model.wr(8'h12, 8'h52);
    gate_pin_in = 4'hd;
    step();
    chk("pol", 8'(output_gate_polarity_out), 8'h0d);
    chk("en", 8'(pair_enable_out), 8'h0f);
    gate_pin_in = 4'h2;
    power_good_powerdown_pin_in = 1'b0;
    step();
    chk("pd", 8'(powerdown_out), 8'h01);
    chk("en", 8'(pair_enable_out), 8'h00);
    chk("clr", {stop_state_sel_out, pair_impedance_sel_out[5:0]}, 8'h2a);
    power_good_powerdown_pin_in = 1'b1;
    i_cbo_host_model.wr(8'h0a, 8'h40);
    i_cbo_host_model.wr(8'h0b, 8'h03);
    i_cbo_host_model.wr(8'h13, 8'h01);
    chk("pdpol", 8'(powerdown_polarity_out), 8'h01);
    chk("pd", 8'(powerdown_out), 8'h01);
    step();
    chk("keep", 8'(stop_state_sel_out), 8'h03);
    power_good_powerdown_pin_in = 1'b0;
    step();
    chk("pd", 8'(powerdown_out), 8'h00);
    chk("en", 8'(pair_enable_out), 8'h0d);
    // Mid-run reset must drop the kept configuration without waiting for an edge
    rst_b_in = 1'b0;
    power_good_powerdown_pin_in = 1'b1;
    #1;
    chk("arst", 8'(stop_state_sel_out), 8'h00);
    step();
    step();
    rst_b_in = 1'b1;
    check_defaults();
    i_cbo_host_model.wr(8'h0b, 8'h02);
    chk("drv", 8'({pair_true_drive_out, pair_comp_drive_out}), 8'h04);
    give_verdict();
  end
endmodule : cbo_config_regs_tb_top

// ==== testbench/cbo_host_model.sv ====
`timescale 1ns/1ns
module cbo_host_model (
  input wire logic clock_in,
  input wire logic [7:0] rd_data_in,
  output logic wr_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out
);
  initial
  begin
    wr_en_out = 1'b0;
    addr_out = 8'h00;
    wr_data_out = 8'h00;
  end
  // Callers pass defined codes only, reserved bits zero, except the 8'hff written to unmapped 8'h11
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    wr_en_out = 1'b1;
    addr_out = a;
    wr_data_out = d;
    @(posedge clock_in);
    #1;
    wr_en_out = 1'b0;
    // Stale data would hide a missed strobe
    wr_data_out = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    #1;
    addr_out = a;
    #4;
    d = rd_data_in;
  endtask : rd
endmodule : cbo_host_model
